// ### logic/pcg_pkg.sv
// Constants for the peripheral clock gating and low-power control block.
// Assumes a 32-bit plain register port with byte-free word access.
package pcg_pkg;

    // Register word addresses on the plain port
    localparam logic [3:0] PCG_ADDR_MAP_HIGH = 4'h0;
    localparam logic [3:0] PCG_ADDR_MAP_LOW = 4'h1;
    localparam logic [3:0] PCG_ADDR_SET_HELPER = 4'h2;
    localparam logic [3:0] PCG_ADDR_CLR_HELPER = 4'h3;
    localparam logic [3:0] PCG_ADDR_LP_CONTROL = 4'h4;
    localparam logic [3:0] PCG_ADDR_WAKE_CONTROL = 4'h5;
    localparam logic [3:0] PCG_ADDR_STATUS = 4'h6;

    // Slots whose clock may really be gated
    localparam logic [31:0] PCG_HIGH_GATEABLE = 32'h0000_071f;
    localparam logic [31:0] PCG_LOW_GATEABLE = 32'hf7e6_1004;

    // Reset values
    localparam logic [31:0] PCG_MAP_RESET = 32'h0000_0000;
    localparam logic [7:0] PCG_LPC_RESET = 8'h00;

    // Low-power control field positions
    localparam int PCG_LPC_MODE_HI = 7;
    localparam int PCG_LPC_MODE_LO = 6;
    localparam int PCG_LPC_FAST_BIT = 5;
    localparam int PCG_LPC_STOP_HI = 4;
    localparam int PCG_LPC_STOP_LO = 3;

    // Helper and wake-up control register fields
    localparam int PCG_HLP_GLOBAL_BIT = 6;
    localparam int PCG_HLP_INDEX_HI = 5;
    localparam int PCG_WCR_ENABLE_BIT = 7;

    // Low-power modes
    localparam logic [1:0] PCG_MODE_RUN = 2'h0;
    localparam logic [1:0] PCG_MODE_DOZE = 2'h1;
    localparam logic [1:0] PCG_MODE_WAIT = 2'h2;
    localparam logic [1:0] PCG_MODE_STOP = 2'h3;

    // Stop-clock selections
    localparam logic [1:0] PCG_STP_SYS = 2'h0;
    localparam logic [1:0] PCG_STP_BUS = 2'h1;
    localparam logic [1:0] PCG_STP_PLL = 2'h2;
    localparam logic [1:0] PCG_STP_ALL = 2'h3;

    typedef enum logic [1:0] {
        PCG_ST_RUN,
        PCG_ST_LOWPOWER,
        PCG_ST_WAKE
    } pcg_state_type;

endpackage

// ### logic/pcg_sync.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the source is a quasi-static level.
`timescale 1ns/1ps
`default_nettype none
module pcg_sync (
    input wire logic clk,   // System clock
    input wire logic rst,   // Async reset, high
    input wire logic ce,    // Clock enable
    input wire logic d,     // Asynchronous level
    output logic q          // Synchronised level
);
    logic meta_q;

    // First flop feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### logic/pcg_map_reg.sv
// One 32-bit gating bitmap with direct write and set/clear helpers.
// Assumes helper index already points into this word.
`timescale 1ns/1ps
`default_nettype none
module pcg_map_reg
    import pcg_pkg::*;
(
    input wire logic clk,           // System clock
    input wire logic rst,           // Async reset, high
    input wire logic ce,            // Clock enable
    input wire logic wr,            // Direct write strobe
    input wire logic [31:0] wdata,  // Direct write data
    input wire logic set_one,       // Set indexed bit
    input wire logic set_all,       // Set every bit
    input wire logic clr_one,       // Clear indexed bit
    input wire logic clr_all,       // Clear every bit
    input wire logic [4:0] idx,     // Bit index for helpers
    output logic [31:0] map_q       // Stored bitmap
);

    // Direct write or helper update; strobes never coincide
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            map_q <= PCG_MAP_RESET;
        end else if (ce) begin
            if (wr) begin
                map_q <= wdata;
            end else if (set_all) begin
                map_q <= 32'hffff_ffff;
            end else if (clr_all) begin
                map_q <= 32'h0000_0000;
            end else if (set_one) begin
                map_q[idx] <= 1'b1;
            end else if (clr_one) begin
                map_q[idx] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/pcg_top.sv
// Peripheral clock gating bitmap and low-power mode control.
// Assumes a plain register port on the system clock and a core that
// pulses I_STOP_EXEC when it executes the stop instruction.
//
// What this block does
// - One disable bit per 16 kByte slot
// - Crossbar and system control clocks never gated
// - Bitmap writable directly and via helpers
// - Bit 0 runs clock, 1 stops it
// - High map gates slots 32-36, 40-42
// - Low map gates 2,12,17,18,21-26,28-31
// - Mode field bits 7-6 selects stop mode
// - Mode field sampled at stop instruction
// - Mode run: core halts, no clock stopped
// - Fast wakeup bit 5 skips lock wait
// - Fast wakeup sampled at stop instruction
// - Limp mode: always re-enable on wakeup
// - Stop-clock field bits 4-3 selects clocks
// - 00 sys,01 +bus,10 +PLL,11 +osc
// - Entry only with entry enable set
// - Helpers set/clear indexed or all; read zero
`timescale 1ns/1ps
`default_nettype none
module pcg_top
    import pcg_pkg::*;
(
    input wire logic I_SYS_CLK,          // 250 MHz system clock
    input wire logic I_RESET,            // Async reset, high
    input wire logic I_CE,               // Clock enable
    input wire logic [3:0] I_ADDR,       // Register word address
    input wire logic [31:0] I_WDATA,     // Write data
    input wire logic I_WR,               // Write strobe
    input wire logic I_RD,               // Read strobe
    input wire logic I_STOP_EXEC,        // Core executed stop, pulse
    input wire logic I_WAKE_REQ,         // Wake request, pulse
    input wire logic I_PLL_LOCK,         // PLL lock, async pin
    input wire logic I_LIMP_MODE,        // Limp mode, async pin
    output logic [31:0] O_RDATA,         // Read data
    output logic [31:0] O_GATE_HIGH,     // Clock stop, slots 32-63
    output logic [31:0] O_GATE_LOW,      // Clock stop, slots 0-31
    output logic O_CORE_HALT,            // Core stopped
    output logic O_SYS_CLK_STOP,         // System clocks stopped
    output logic O_BUS_CLK_STOP,         // External bus clock stopped
    output logic O_PLL_STOP,             // PLL stopped
    output logic O_OSC_STOP,             // Oscillator stopped
    output logic [1:0] O_MODE            // Mode being held
);

    logic [31:0] map_high_q;
    logic [31:0] map_low_q;
    logic [7:0] lpc_q;
    logic wcr_enable_q;
    logic pll_lock_s;
    logic limp_s;
    logic [1:0] mode_q;
    logic [1:0] stop_sel_q;
    logic fast_q;
    pcg_state_type state_q;
    logic [31:0] rdata_d;

    // Decode a write to one address
    function automatic logic wr_hit(input logic [3:0] a);
        wr_hit = I_WR && (I_ADDR == a);
    endfunction

    // Helper decode: global bit, index bit 5 picks word
    logic set_wr;
    logic clr_wr;
    logic hlp_global;
    logic hlp_upper;
    assign set_wr = wr_hit(PCG_ADDR_SET_HELPER);
    assign clr_wr = wr_hit(PCG_ADDR_CLR_HELPER);
    assign hlp_global = I_WDATA[PCG_HLP_GLOBAL_BIT];
    assign hlp_upper = I_WDATA[PCG_HLP_INDEX_HI];

    // Lock and limp come from pins, so synchronise them
    pcg_sync u_sync_lock (
        .clk(I_SYS_CLK),
        .rst(I_RESET),
        .ce(I_CE),
        .d(I_PLL_LOCK),
        .q(pll_lock_s)
    );

    pcg_sync u_sync_limp (
        .clk(I_SYS_CLK),
        .rst(I_RESET),
        .ce(I_CE),
        .d(I_LIMP_MODE),
        .q(limp_s)
    );

    // Slots 32-63: one bit each
    pcg_map_reg u_map_high (
        .clk(I_SYS_CLK),
        .rst(I_RESET),
        .ce(I_CE),
        .wr(wr_hit(PCG_ADDR_MAP_HIGH)),
        .wdata(I_WDATA),
        .set_one(set_wr && !hlp_global && hlp_upper),
        .set_all(set_wr && hlp_global),
        .clr_one(clr_wr && !hlp_global && hlp_upper),
        .clr_all(clr_wr && hlp_global),
        .idx(I_WDATA[4:0]),
        .map_q(map_high_q)
    );

    // Slots 0-31: one bit each
    pcg_map_reg u_map_low (
        .clk(I_SYS_CLK),
        .rst(I_RESET),
        .ce(I_CE),
        .wr(wr_hit(PCG_ADDR_MAP_LOW)),
        .wdata(I_WDATA),
        .set_one(set_wr && !hlp_global && !hlp_upper),
        .set_all(set_wr && hlp_global),
        .clr_one(clr_wr && !hlp_global && !hlp_upper),
        .clr_all(clr_wr && hlp_global),
        .idx(I_WDATA[4:0]),
        .map_q(map_low_q)
    );

    // Low-power control: fields readable and writable in any mode
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            lpc_q <= PCG_LPC_RESET;
        end else if (I_CE && wr_hit(PCG_ADDR_LP_CONTROL)) begin
            lpc_q <= {I_WDATA[7:3], 3'h0};
        end
    end

    // Entry enable, stored in the wake-up control word
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            wcr_enable_q <= 1'b0;
        end else if (I_CE && wr_hit(PCG_ADDR_WAKE_CONTROL)) begin
            wcr_enable_q <= I_WDATA[PCG_WCR_ENABLE_BIT];
        end
    end

    // Stop sequencer; fields latched only at the stop instruction
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_q <= PCG_ST_RUN;
            mode_q <= PCG_MODE_RUN;
            stop_sel_q <= PCG_STP_SYS;
            fast_q <= 1'b0;
        end else if (I_CE) begin
            case (state_q)
                PCG_ST_RUN: begin
                    if (I_STOP_EXEC && wcr_enable_q) begin
                        state_q <= PCG_ST_LOWPOWER;
                        // Later writes do not affect this entry
                        mode_q <= lpc_q[PCG_LPC_MODE_HI:PCG_LPC_MODE_LO];
                        stop_sel_q <= lpc_q[PCG_LPC_STOP_HI:PCG_LPC_STOP_LO];
                        fast_q <= lpc_q[PCG_LPC_FAST_BIT];
                    end
                end
                PCG_ST_LOWPOWER: begin
                    if (I_WAKE_REQ) begin
                        state_q <= PCG_ST_WAKE;
                    end
                end
                PCG_ST_WAKE: begin
                    // Only stop mode waits for lock; limp never locks
                    if (mode_q != PCG_MODE_STOP || fast_q || limp_s
                        || pll_lock_s) begin
                        state_q <= PCG_ST_RUN;
                        mode_q <= PCG_MODE_RUN;
                    end
                end
                default: begin
                    state_q <= PCG_ST_RUN;
                end
            endcase
        end
    end

    // Clock stops; run mode halts core but stops no clock
    logic in_lp;
    logic in_stop;
    logic lp_clocks;
    assign in_lp = (state_q != PCG_ST_RUN);
    assign in_stop = (state_q == PCG_ST_LOWPOWER)
        && (mode_q == PCG_MODE_STOP);
    assign lp_clocks = in_lp && (mode_q != PCG_MODE_RUN);

    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_CORE_HALT <= 1'b0;
            O_SYS_CLK_STOP <= 1'b0;
            O_BUS_CLK_STOP <= 1'b0;
            O_PLL_STOP <= 1'b0;
            O_OSC_STOP <= 1'b0;
            O_MODE <= PCG_MODE_RUN;
        end else if (I_CE) begin
            O_CORE_HALT <= in_lp;
            O_SYS_CLK_STOP <= lp_clocks;
            O_BUS_CLK_STOP <= in_stop && (stop_sel_q != PCG_STP_SYS);
            O_PLL_STOP <= in_stop && (stop_sel_q == PCG_STP_PLL
                || stop_sel_q == PCG_STP_ALL);
            O_OSC_STOP <= in_stop && (stop_sel_q == PCG_STP_ALL);
            O_MODE <= mode_q;
        end
    end

    // Gate outputs: unassigned slots and crossbar/control never gate
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_GATE_HIGH <= 32'h0000_0000;
            O_GATE_LOW <= 32'h0000_0000;
        end else if (I_CE) begin
            O_GATE_HIGH <= map_high_q & PCG_HIGH_GATEABLE;
            O_GATE_LOW <= map_low_q & PCG_LOW_GATEABLE;
        end
    end

    // Read mux; helpers and unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (I_ADDR)
            PCG_ADDR_MAP_HIGH: rdata_d = map_high_q;
            PCG_ADDR_MAP_LOW: rdata_d = map_low_q;
            PCG_ADDR_LP_CONTROL: rdata_d = {24'h00_0000, lpc_q};
            PCG_ADDR_WAKE_CONTROL: rdata_d = {24'h00_0000, wcr_enable_q,
                7'h00};
            PCG_ADDR_STATUS: rdata_d = {26'h000_0000, limp_s, pll_lock_s,
                state_q != PCG_ST_RUN, fast_q, mode_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_RDATA <= 32'h0000_0000;
        end else if (I_CE) begin
            O_RDATA <= I_RD ? rdata_d : 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// ### test/pcg_checker.sv
// Port checker for pcg_top, bound onto every instance.
// Assumes map-follow checks start only on writes taken with enable high.
`timescale 1ns/1ps
`default_nettype none
module pcg_checker
    import pcg_pkg::*;
(
    input wire logic I_SYS_CLK, // Clock
    input wire logic I_RESET, // Reset
    input wire logic I_CE, // Enable
    input wire logic [3:0] I_ADDR, // Address
    input wire logic [31:0] I_WDATA, // Write data
    input wire logic I_WR, // Write
    input wire logic I_RD, // Read
    input wire logic I_STOP_EXEC, // Stop
    input wire logic I_WAKE_REQ, // Wake
    input wire logic I_PLL_LOCK, // Lock
    input wire logic I_LIMP_MODE, // Limp
    input wire logic [31:0] O_RDATA, // Read data
    input wire logic [31:0] O_GATE_HIGH, // Gates high
    input wire logic [31:0] O_GATE_LOW, // Gates low
    input wire logic O_CORE_HALT, // Halt
    input wire logic O_SYS_CLK_STOP, // Sys stop
    input wire logic O_BUS_CLK_STOP, // Bus stop
    input wire logic O_PLL_STOP, // PLL stop
    input wire logic O_OSC_STOP, // Osc stop
    input wire logic [1:0] O_MODE // Mode
);
    localparam logic [31:0] hi_slots = 32'h0000_071f;
    localparam logic [31:0] lo_slots = 32'hf7e6_1004;
    default clocking dc @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RESET);

    // Map write, then no map-changing write for the gate pipeline
    sequence hi_write_s;
        I_CE && I_WR && I_ADDR == PCG_ADDR_MAP_HIGH
        ##1 !(I_WR && I_ADDR <= PCG_ADDR_CLR_HELPER) [*3];
    endsequence
    sequence lo_write_s;
        I_CE && I_WR && I_ADDR == PCG_ADDR_MAP_LOW
        ##1 !(I_WR && I_ADDR <= PCG_ADDR_CLR_HELPER) [*3];
    endsequence

    // Gates track the map, only on assigned slots
    hi_follow_a: assert property (hi_write_s |->
        O_GATE_HIGH == ($past(I_WDATA, 3) & hi_slots))
        else $error("high gates do not follow map");
    lo_follow_a: assert property (lo_write_s |->
        O_GATE_LOW == ($past(I_WDATA, 3) & lo_slots))
        else $error("low gates do not follow map");
    hi_mask_a: assert property ((O_GATE_HIGH & ~hi_slots) == 32'h0)
        else $error("unassigned high slot gated");
    lo_mask_a: assert property ((O_GATE_LOW & ~lo_slots) == 32'h0)
        else $error("unassigned low slot gated");

    // Read-back of helpers and reserved control bits
    helper_zero_a: assert property (I_RD &&
        (I_ADDR == PCG_ADDR_SET_HELPER || I_ADDR == PCG_ADDR_CLR_HELPER)
        |=> O_RDATA == 32'h0) else $error("helper read not zero");
    lpc_reserved_a: assert property (I_RD &&
        I_ADDR == PCG_ADDR_LP_CONTROL |=> O_RDATA[31:8] == 24'h0 &&
        O_RDATA[2:0] == 3'h0) else $error("control reserved bits set");

    // Low-power entry and clock stop ordering
    halt_cause_a: assert property ($rose(O_CORE_HALT) |->
        $past(I_STOP_EXEC, 2) || $past(I_STOP_EXEC, 3))
        else $error("halt without stop");
    clock_chain_a: assert property ((O_OSC_STOP <= O_PLL_STOP) &&
        (O_PLL_STOP <= O_BUS_CLK_STOP) && (O_BUS_CLK_STOP <= O_SYS_CLK_STOP))
        else $error("clock stop order broken");
    bus_mode_a: assert property (O_BUS_CLK_STOP |->
        O_MODE == PCG_MODE_STOP && O_CORE_HALT) else $error("bus stop off mode");
    run_clocks_a: assert property (O_MODE == PCG_MODE_RUN |->
        !O_SYS_CLK_STOP) else $error("run mode stopped clocks");
    mode_hold_a: assert property (O_CORE_HALT && $past(O_CORE_HALT) |->
        $stable(O_MODE)) else $error("mode changed while halted");
endmodule

bind pcg_top pcg_checker u_pcg_checker (.I_SYS_CLK(I_SYS_CLK),
    .I_RESET(I_RESET), .I_CE(I_CE), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .I_STOP_EXEC(I_STOP_EXEC),
    .I_WAKE_REQ(I_WAKE_REQ), .I_PLL_LOCK(I_PLL_LOCK),
    .I_LIMP_MODE(I_LIMP_MODE), .O_RDATA(O_RDATA), .O_GATE_HIGH(O_GATE_HIGH),
    .O_GATE_LOW(O_GATE_LOW), .O_CORE_HALT(O_CORE_HALT),
    .O_SYS_CLK_STOP(O_SYS_CLK_STOP), .O_BUS_CLK_STOP(O_BUS_CLK_STOP),
    .O_PLL_STOP(O_PLL_STOP), .O_OSC_STOP(O_OSC_STOP), .O_MODE(O_MODE));
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for pcg_top through its register port.
// Assumes the checker is bound in; enable drops once, near the end.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcg_pkg::*;
    localparam logic [31:0] hi_slots = 32'h0000_071f; // Slots 32-36, 40-42
    localparam logic [31:0] lo_slots = 32'hf7e6_1004; // Assigned low slots
    logic clk, rst, ce, wr_stb, rd_stb, stop_exec, wake_req, pll_lock, limp;
    logic halt, sys_stop, bus_stop, pll_stop, osc_stop;
    logic [1:0] mode;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, gate_hi, gate_lo, got;
    int bad_count, check_count;

    pcg_top u_pcg_top (.I_SYS_CLK(clk), .I_RESET(rst), .I_CE(ce),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_stb), .I_RD(rd_stb),
        .I_STOP_EXEC(stop_exec), .I_WAKE_REQ(wake_req),
        .I_PLL_LOCK(pll_lock), .I_LIMP_MODE(limp), .O_RDATA(rdata),
        .O_GATE_HIGH(gate_hi), .O_GATE_LOW(gate_lo), .O_CORE_HALT(halt),
        .O_SYS_CLK_STOP(sys_stop), .O_BUS_CLK_STOP(bus_stop),
        .O_PLL_STOP(pll_stop), .O_OSC_STOP(osc_stop), .O_MODE(mode));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic finish_test;
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask

    // Bus cycles; one idle cycle after each keeps strobes single-driven
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic pulse(input logic w);
        @(posedge clk);
        if (w)
            wake_req <= 1'b1;
        else
            stop_exec <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        stop_exec <= 1'b0;
    endtask

    // Bounded wait on the halt level; running out ends the run
    task automatic wait_halt(input logic e);
        int n;
        n = 0;
        while (halt !== e && n < 12) begin
            @(posedge clk);
            #1 n++;
        end
        chk({31'h0, halt}, {31'h0, e});
        if (halt !== e)
            finish_test();
    endtask

    task automatic maps(input logic [31:0] h, input logic [31:0] l);
        reg_read(PCG_ADDR_MAP_HIGH, got);
        chk(got, h);
        reg_read(PCG_ADDR_MAP_LOW, got);
        chk(got, l);
        chk(gate_hi, h & hi_slots);
        chk(gate_lo, l & lo_slots);
    endtask

    // Enter low power and compare every clock stop against the tables
    task automatic enter(input logic [1:0] m, input logic f,
        input logic [1:0] s);
        logic [2:0] e;
        e = (m == PCG_MODE_STOP) ? {s != 2'h0, s[1], s == 2'h3} : 3'h0;
        reg_write(PCG_ADDR_LP_CONTROL, {24'h0, m, f, s, 3'h0});
        pulse(1'b0);
        wait_halt(1'b1);
        repeat (2) @(posedge clk);
        #1 chk({30'h0, mode}, {30'h0, m});
        chk({31'h0, sys_stop}, {31'h0, m != PCG_MODE_RUN});
        chk({29'h0, bus_stop, pll_stop, osc_stop}, {29'h0, e});
    endtask

    initial begin
        {rst, ce} = 2'h3;
        {wr_stb, rd_stb, stop_exec, wake_req, pll_lock, limp} = 6'h0;
        addr = 4'h0;
        wdata = 32'h0;
        bad_count = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            reg_read(4'(a), got);
            chk(got, 32'h0);
        end
        // Unmapped write in between keeps both map-follow checks live
        reg_write(PCG_ADDR_MAP_LOW, 32'hffff_ffff);
        reg_write(4'h9, 32'h0);
        reg_write(PCG_ADDR_MAP_HIGH, 32'hffff_ffff);
        maps(32'hffff_ffff, 32'hffff_ffff);
        reg_write(PCG_ADDR_CLR_HELPER, 32'h40);
        maps(32'h0, 32'h0);
        reg_write(PCG_ADDR_SET_HELPER, 32'h28);
        reg_write(PCG_ADDR_SET_HELPER, 32'h02);
        reg_write(PCG_ADDR_SET_HELPER, 32'h00);
        maps(32'h100, 32'h5);
        reg_write(PCG_ADDR_CLR_HELPER, 32'h28);
        maps(32'h0, 32'h5);
        reg_write(PCG_ADDR_SET_HELPER, 32'h40);
        reg_write(PCG_ADDR_CLR_HELPER, 32'h22);
        maps(32'hffff_fffb, 32'hffff_ffff);
        reg_write(PCG_ADDR_CLR_HELPER, 32'h40);
        reg_write(PCG_ADDR_LP_CONTROL, 32'hff);
        reg_read(PCG_ADDR_LP_CONTROL, got);
        chk(got, 32'hf8);
        // Stop is refused until entry is enabled
        pulse(1'b0);
        repeat (12) @(posedge clk);
        #1 chk({31'h0, halt}, 32'h0);
        reg_write(PCG_ADDR_WAKE_CONTROL, 32'h80);
        for (int k = 0; k < 7; k++) begin
            enter(k < 4 ? 2'h3 : 2'(k - 4), 1'b1, k < 4 ? 2'(k) : 2'h0);
            pulse(1'b1);
            wait_halt(1'b0);
        end
        // Late fast bit is ignored; wake waits for lock
        enter(PCG_MODE_STOP, 1'b0, 2'h1);
        reg_write(PCG_ADDR_LP_CONTROL, 32'h20);
        pulse(1'b1);
        repeat (12) @(posedge clk);
        #1 chk({31'h0, halt}, 32'h1);
        @(posedge clk);
        pll_lock <= 1'b1;
        wait_halt(1'b0);
        @(posedge clk);
        pll_lock <= 1'b0;
        limp <= 1'b1;
        enter(PCG_MODE_STOP, 1'b0, 2'h2);
        pulse(1'b1);
        wait_halt(1'b0);
        // Enable low freezes state, so this write must not land
        @(posedge clk);
        ce <= 1'b0;
        reg_write(PCG_ADDR_MAP_HIGH, 32'h0000_0001);
        @(posedge clk);
        ce <= 1'b1;
        maps(32'h0, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
